// ==== dtc_params.svh ====
/*
 Register offsets, field positions, reset values and timing counts of the
 dual timer/counter block. Assumes inclusion by its bare name only.
*/
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// Register byte addresses on the 32-bit bus
`define DTC_OFS_CTRL      12'h088
`define DTC_OFS_T0_HIGH   12'h08C
`define DTC_OFS_MODE      12'h090
`define DTC_OFS_T0_LOW    12'h094
`define DTC_OFS_T1_HIGH   12'h098
`define DTC_OFS_T1_LOW    12'h09C
`define DTC_OFS_IRQ_STAT  12'h0A0
`define DTC_OFS_IRQ_MASK  12'h0A4
`define DTC_OFS_VECT_ACK  12'h0A8

// Control register bit positions
`define DTC_B_TF1 7
`define DTC_B_TR1 6
`define DTC_B_TF0 5
`define DTC_B_TR0 4
`define DTC_B_IE1 3
`define DTC_B_IT1 2
`define DTC_B_IE0 1
`define DTC_B_IT0 0

// Mode register bit positions, per timer nibble
`define DTC_B_TIMER_ONE_PIN_GATING 7
`define DTC_B_SRC1  6
`define DTC_B_TIMER_ZERO_PIN_GATING 3
`define DTC_B_SRC0  2

// Status, mask and acknowledge bit positions
`define DTC_S_T0  0
`define DTC_S_T1  1
`define DTC_S_X0  2
`define DTC_S_X1  3

// Reset values
`define DTC_RST_CTRL  8'h00
`define DTC_RST_MODE  8'h00
`define DTC_RST_COUNT 8'h00

// Peripheral cycle in system clocks: the internal count rate
`define DTC_PER_DIV   3'h6

// Bus responses
`define DTC_RESP_OKAY   2'h0
`define DTC_RESP_SLVERR 2'h2

`endif

// ==== dtc_pkg.sv ====
/*
 Types of the dual timer/counter block.
 Assumes dtc_params.svh is compiled alongside.
*/
package dtc_pkg;
   typedef enum logic [1:0] {
      DTC_M13   = 2'b00,
      DTC_M16   = 2'b01,
      DTC_M8AR  = 2'b10,
      DTC_MSPLT = 2'b11
   } dtc_mode_type;
endpackage

// ==== dtc_pin_sync.sv ====
/*
 Three-stage pin synchroniser with agreement filter.
 Assumes an asynchronous pin input and the system clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_sync (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Pin and filtered level
   input  wire logic pin_in,
   output var  logic level_q
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Level only moves once two later stages agree
   always_ff @(posedge clk) begin
      if (rst) begin
         level_q <= 1'b1;
      end else if (s2_q == s3_q) begin
         level_q <= s2_q;
      end
   end
endmodule
`default_nettype wire

// ==== dtc_top.sv ====
/*
 Dual timer/counter with external interrupt flags behind an AXI4-Lite slave.
 Assumes pins idle high, one master, one write and one read at a time.
*/
// Function
// - Overflow sets control flags, bits 5 and 7
// - Vector acknowledge clears timer overflow flag
// - Timer 0 counts only while run bit 4; in mode three its high byte counts on run bit 6
// - Timer 1 counts only while run bit 6, or whenever timer 0 is in mode three
// - Type zero: low pin level requests
// - Type one: falling pin edge requests
// - Detected condition sets external interrupt flag
// - Edge flag cleared when interrupt processed
// - Source zero counts divided system clock
// - Source one counts count pin falls
// - Mode one is cascaded 16-bit counter
// - Mode two reloads low from high
// - Mode and timer 0 high reset zero
// - Gating needs run and high pin
// - Mode zero: 5-bit prescaler, 8-bit high
// - Timer 0 mode three splits bytes
// - Timer 1 mode three holds count
`timescale 1ns/1ps
`default_nettype none
`include "dtc_params.svh"
module dtc_top import dtc_pkg::*; (
   // Clock and reset
   input  wire logic        CLK_SYS,
   input  wire logic        SYS_RST,
   // AXI4-Lite write
   input  wire logic [11:0] AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   // AXI4-Lite read
   input  wire logic [11:0] ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY,
   // Pins
   input  wire logic        COUNT_PIN_ZERO,
   input  wire logic        COUNT_PIN_ONE,
   input  wire logic        EXT_IRQ_ZERO_PIN,
   input  wire logic        EXT_IRQ_ONE_PIN,
   // Interrupt
   output logic             IRQ
);
   logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q, irq_q;
   logic        aw_hold_q, w_hold_q, wstrb0_q;
   logic [11:0] awaddr_q;
   logic [7:0]  wdata_q;
   logic [1:0]  bresp_q, rresp_q;
   logic [7:0]  rdata_q;
   logic        tf0_q, tf1_q, tr0_q, tr1_q, ie0_q, ie1_q, it0_q, it1_q;
   logic [7:0]  mode_q, th0_q, tl0_q, th1_q, tl1_q;
   logic [3:0]  stat_q, mask_q;
   logic [2:0]  div_q;
   logic        tick;
   logic        cp0_lvl, cp1_lvl, xi0_lvl, xi1_lvl;
   logic        cp0_smp_q, cp1_smp_q, xi0_prev_q, xi1_prev_q;

   assign AWREADY = awready_q;
   assign WREADY  = wready_q;
   assign BVALID  = bvalid_q;
   assign BRESP   = bresp_q;
   assign ARREADY = arready_q;
   assign RVALID  = rvalid_q;
   assign RRESP   = rresp_q;
   assign RDATA   = {24'h000000, rdata_q};
   assign IRQ     = irq_q;

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == `DTC_OFS_CTRL) || (a == `DTC_OFS_T0_HIGH) || (a == `DTC_OFS_MODE) ||
               (a == `DTC_OFS_T0_LOW) || (a == `DTC_OFS_T1_HIGH) || (a == `DTC_OFS_T1_LOW) ||
               (a == `DTC_OFS_IRQ_STAT) || (a == `DTC_OFS_IRQ_MASK) ||
               (a == `DTC_OFS_VECT_ACK);
   endfunction

   // One count step: {overflow, high, low}
   function automatic logic [16:0] tmr_step(input dtc_mode_type m,
                                            input logic [7:0] th,
                                            input logic [7:0] tl);
      logic [15:0] w;
      begin
         w = {th, tl} + 16'h0001;
         case (m)
            DTC_M13: begin
               if (tl[4:0] == 5'h1F) begin
                  tmr_step = {th == 8'hFF, th + 8'h01, tl[7:5], 5'h00};
               end else begin
                  tmr_step = {1'b0, th, tl[7:5], tl[4:0] + 5'h01};
               end
            end
            DTC_M16: tmr_step = {&{th, tl}, w};
            DTC_M8AR: begin
               if (tl == 8'hFF) begin
                  tmr_step = {1'b1, th, th};
               end else begin
                  tmr_step = {1'b0, th, tl + 8'h01};
               end
            end
            default: tmr_step = {&tl, th, tl + 8'h01};
         endcase
      end
   endfunction

   // Pin conditioning
   dtc_pin_sync u_cp0 (.clk(CLK_SYS), .rst(SYS_RST), .pin_in(COUNT_PIN_ZERO),   .level_q(cp0_lvl));
   dtc_pin_sync u_cp1 (.clk(CLK_SYS), .rst(SYS_RST), .pin_in(COUNT_PIN_ONE),    .level_q(cp1_lvl));
   dtc_pin_sync u_xi0 (.clk(CLK_SYS), .rst(SYS_RST), .pin_in(EXT_IRQ_ZERO_PIN), .level_q(xi0_lvl));
   dtc_pin_sync u_xi1 (.clk(CLK_SYS), .rst(SYS_RST), .pin_in(EXT_IRQ_ONE_PIN),  .level_q(xi1_lvl));

   // Bus write channel
   logic wr_do;
   logic [11:0] wa;
   assign wr_do = aw_hold_q && w_hold_q && !bvalid_q;
   assign wa    = awaddr_q;

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         aw_hold_q <= 1'b0;
         awready_q <= 1'b0;
         awaddr_q  <= 12'h000;
      end else if (AWVALID && awready_q) begin
         aw_hold_q <= 1'b1;
         awready_q <= 1'b0;
         awaddr_q  <= {AWADDR[11:2], 2'b00};
      end else if (wr_do) begin
         aw_hold_q <= 1'b0;
      end else if (!aw_hold_q && !bvalid_q) begin
         awready_q <= 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         w_hold_q <= 1'b0;
         wready_q <= 1'b0;
         wdata_q  <= 8'h00;
         wstrb0_q <= 1'b0;
      end else if (WVALID && wready_q) begin
         w_hold_q <= 1'b1;
         wready_q <= 1'b0;
         wdata_q  <= WDATA[7:0];
         wstrb0_q <= WSTRB[0];
      end else if (wr_do) begin
         w_hold_q <= 1'b0;
      end else if (!w_hold_q && !bvalid_q) begin
         wready_q <= 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         bvalid_q <= 1'b0;
         bresp_q  <= `DTC_RESP_OKAY;
      end else if (wr_do) begin
         bvalid_q <= 1'b1;
         bresp_q  <= mapped(wa) ? `DTC_RESP_OKAY : `DTC_RESP_SLVERR;
      end else if (bvalid_q && BREADY) begin
         bvalid_q <= 1'b0;
      end
   end

   // Byte write strobes per register; upper lanes carry nothing
   logic we_ctrl, we_mode, we_th0, we_tl0, we_th1, we_tl1, we_stat, we_mask, we_ack;
   assign we_ctrl = wr_do && wstrb0_q && (wa == `DTC_OFS_CTRL);
   assign we_mode = wr_do && wstrb0_q && (wa == `DTC_OFS_MODE);
   assign we_th0  = wr_do && wstrb0_q && (wa == `DTC_OFS_T0_HIGH);
   assign we_tl0  = wr_do && wstrb0_q && (wa == `DTC_OFS_T0_LOW);
   assign we_th1  = wr_do && wstrb0_q && (wa == `DTC_OFS_T1_HIGH);
   assign we_tl1  = wr_do && wstrb0_q && (wa == `DTC_OFS_T1_LOW);
   assign we_stat = wr_do && wstrb0_q && (wa == `DTC_OFS_IRQ_STAT);
   assign we_mask = wr_do && wstrb0_q && (wa == `DTC_OFS_IRQ_MASK);
   assign we_ack  = wr_do && wstrb0_q && (wa == `DTC_OFS_VECT_ACK);

   logic ack_t0, ack_t1, ack_x0, ack_x1;
   assign ack_t0 = we_ack && wdata_q[`DTC_S_T0];
   assign ack_t1 = we_ack && wdata_q[`DTC_S_T1];
   assign ack_x0 = we_ack && wdata_q[`DTC_S_X0];
   assign ack_x1 = we_ack && wdata_q[`DTC_S_X1];

   // Peripheral cycle tick and count pin sampling
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         div_q <= 3'h0;
      end else if (div_q == `DTC_PER_DIV - 3'h1) begin
         div_q <= 3'h0;
      end else begin
         div_q <= div_q + 3'h1;
      end
   end
   assign tick = (div_q == `DTC_PER_DIV - 3'h1);

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         cp0_smp_q <= 1'b1;
         cp1_smp_q <= 1'b1;
      end else if (tick) begin
         cp0_smp_q <= cp0_lvl;
         cp1_smp_q <= cp1_lvl;
      end
   end

   // Count enables and steps
   dtc_mode_type m0, m1;
   logic t0_split, inc0, inc1, run0, run1, t1_hold;
   logic [16:0] st0, st1, sth;
   logic ovf0, ovf1, ovfh;
   assign m0       = dtc_mode_type'(mode_q[1:0]);
   assign m1       = dtc_mode_type'(mode_q[5:4]);
   assign t0_split = (m0 == DTC_MSPLT);
   assign t1_hold  = (m1 == DTC_MSPLT);
   assign run0     = tr0_q && (!mode_q[`DTC_B_TIMER_ZERO_PIN_GATING] || xi0_lvl);
   assign run1     = t0_split || (tr1_q && (!mode_q[`DTC_B_TIMER_ONE_PIN_GATING] || xi1_lvl));
   assign inc0     = run0 && (mode_q[`DTC_B_SRC0] ? (tick && cp0_smp_q && !cp0_lvl) : tick);
   assign inc1     = run1 && !t1_hold &&
                     (mode_q[`DTC_B_SRC1] ? (tick && cp1_smp_q && !cp1_lvl) : tick);
   assign st0      = tmr_step(m0, th0_q, tl0_q);
   assign st1      = tmr_step(m1, th1_q, tl1_q);
   assign sth      = tmr_step(DTC_MSPLT, 8'h00, th0_q);
   assign ovf0     = inc0 && st0[16];
   assign ovf1     = inc1 && st1[16] && !t0_split;
   assign ovfh     = t0_split && tr1_q && tick && sth[16];

   // Timer 0 count bytes; a software write beats a count step
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         th0_q <= `DTC_RST_COUNT;
         tl0_q <= `DTC_RST_COUNT;
      end else begin
         if (we_th0) begin
            th0_q <= wdata_q;
         end else if (t0_split) begin
            if (tr1_q && tick) begin
               th0_q <= sth[7:0];
            end
         end else if (inc0) begin
            th0_q <= st0[15:8];
         end
         if (we_tl0) begin
            tl0_q <= wdata_q;
         end else if (inc0) begin
            tl0_q <= st0[7:0];
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         th1_q <= `DTC_RST_COUNT;
         tl1_q <= `DTC_RST_COUNT;
      end else begin
         if (we_th1) begin
            th1_q <= wdata_q;
         end else if (inc1) begin
            th1_q <= st1[15:8];
         end
         if (we_tl1) begin
            tl1_q <= wdata_q;
         end else if (inc1) begin
            tl1_q <= st1[7:0];
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         mode_q <= `DTC_RST_MODE;
      end else if (we_mode) begin
         mode_q <= wdata_q;
      end
   end

   // Control register; hardware set wins over a clearing write or acknowledge
   logic x0_fall, x1_fall;
   assign x0_fall = xi0_prev_q && !xi0_lvl;
   assign x1_fall = xi1_prev_q && !xi1_lvl;

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         {tf1_q, tr1_q, tf0_q, tr0_q, ie1_q, it1_q, ie0_q, it0_q} <= `DTC_RST_CTRL;
         xi0_prev_q <= 1'b1;
         xi1_prev_q <= 1'b1;
      end else begin
         xi0_prev_q <= xi0_lvl;
         xi1_prev_q <= xi1_lvl;
         if (we_ctrl) begin
            tr0_q <= wdata_q[`DTC_B_TR0];
            tr1_q <= wdata_q[`DTC_B_TR1];
            it0_q <= wdata_q[`DTC_B_IT0];
            it1_q <= wdata_q[`DTC_B_IT1];
         end
         if (ovf0) begin
            tf0_q <= 1'b1;
         end else if (we_ctrl) begin
            tf0_q <= wdata_q[`DTC_B_TF0];
         end else if (ack_t0) begin
            tf0_q <= 1'b0;
         end
         if (ovf1 || ovfh) begin
            tf1_q <= 1'b1;
         end else if (we_ctrl) begin
            tf1_q <= wdata_q[`DTC_B_TF1];
         end else if (ack_t1) begin
            tf1_q <= 1'b0;
         end
         if (!it0_q) begin
            ie0_q <= !xi0_lvl;
         end else if (x0_fall) begin
            ie0_q <= 1'b1;
         end else if (we_ctrl) begin
            ie0_q <= wdata_q[`DTC_B_IE0];
         end else if (ack_x0) begin
            ie0_q <= 1'b0;
         end
         if (!it1_q) begin
            ie1_q <= !xi1_lvl;
         end else if (x1_fall) begin
            ie1_q <= 1'b1;
         end else if (we_ctrl) begin
            ie1_q <= wdata_q[`DTC_B_IE1];
         end else if (ack_x1) begin
            ie1_q <= 1'b0;
         end
      end
   end

   // Sticky status, mask and interrupt line
   logic [3:0] ev;
   assign ev = {it1_q ? x1_fall : !xi1_lvl, it0_q ? x0_fall : !xi0_lvl, ovf1 || ovfh, ovf0};

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         stat_q <= 4'h0;
         mask_q <= 4'h0;
         irq_q  <= 1'b0;
      end else begin
         stat_q <= ev | (stat_q & ~(we_stat ? wdata_q[3:0] : 4'h0));
         if (we_mask) begin
            mask_q <= wdata_q[3:0];
         end
         irq_q <= |(stat_q & mask_q);
      end
   end

   // Read channel: one cycle from address to data
   logic [7:0] ctrl_v;
   assign ctrl_v = {tf1_q, tr1_q, tf0_q, tr0_q, ie1_q, it1_q, ie0_q, it0_q};

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 8'h00;
         rresp_q   <= `DTC_RESP_OKAY;
      end else if (ARVALID && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rresp_q   <= mapped({ARADDR[11:2], 2'b00}) ? `DTC_RESP_OKAY : `DTC_RESP_SLVERR;
         case ({ARADDR[11:2], 2'b00})
            `DTC_OFS_CTRL:     rdata_q <= ctrl_v;
            `DTC_OFS_T0_HIGH:  rdata_q <= th0_q;
            `DTC_OFS_MODE:     rdata_q <= mode_q;
            `DTC_OFS_T0_LOW:   rdata_q <= tl0_q;
            `DTC_OFS_T1_HIGH:  rdata_q <= th1_q;
            `DTC_OFS_T1_LOW:   rdata_q <= tl1_q;
            `DTC_OFS_IRQ_STAT: rdata_q <= {4'h0, stat_q};
            `DTC_OFS_IRQ_MASK: rdata_q <= {4'h0, mask_q};
            default:           rdata_q <= 8'h00;
         endcase
      end else if (rvalid_q && RREADY) begin
         rvalid_q <= 1'b0;
      end else if (!rvalid_q) begin
         arready_q <= 1'b1;
      end
   end

   // Checks
   a_ovf0_sets_flag: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) ovf0 |=> tf0_q) else $error("timer 0 overflow lost");
   a_ack_clears_tf0: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) ack_t0 && !ovf0 && !we_ctrl |=> !tf0_q) else $error("acknowledge did not clear");
   a_run0_holds: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) !tr0_q && !we_tl0 |=> $stable(tl0_q)) else $error("timer 0 moved while stopped");
   a_run1_holds: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) !tr1_q && !t0_split && !we_tl1 |=> $stable(tl1_q)) else $error("timer 1 moved while stopped");
   a_level_follow: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) !it0_q |=> ie0_q == !$past(xi0_lvl)) else $error("level flag wrong");
   a_edge_sets: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) it1_q && x1_fall |=> ie1_q) else $error("edge flag not set");
   a_reload_low: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) m0 == DTC_M8AR && ovf0 && !we_tl0 && !we_th0 |=> tl0_q == th0_q) else $error("reload missed");
   a_t1_hold: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) t1_hold && !we_th1 && !we_tl1 |=> $stable({th1_q, tl1_q})) else $error("timer 1 not held");
   a_gate_blocks: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) mode_q[`DTC_B_TIMER_ZERO_PIN_GATING] && !xi0_lvl && !we_tl0 |=> $stable(tl0_q)) else $error("gate ignored");
   a_irq_line: assert property (@(posedge CLK_SYS) disable iff (SYS_RST) ##1 IRQ == |($past(stat_q) & $past(mask_q))) else $error("interrupt line wrong");
   c_t0_overflow: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) ovf0);
   c_split_high: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) ovfh);
   c_edge_ack: cover property (@(posedge CLK_SYS) disable iff (SYS_RST) ie1_q && it1_q ##1 ack_x1);
endmodule
`default_nettype wire

// ==== dtc_pin_model.sv ====
/*
 Count pin driver standing in for the outside world.
 Assumes the bench pulses go for one clock and waits for busy_q to fall.
*/
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // Command
   input  wire logic       go,
   input  wire logic [7:0] pulses,
   // Pin and progress
   output var  logic       pin_q,
   output var  logic       busy_q
);
   logic [7:0] left_q;
   logic [4:0] tick_q;
   // Each level held 16 clocks, over two peripheral cycles, so no edge is lost
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_q <= 1'b1;
         busy_q <= 1'b0;
         left_q <= 8'h00;
         tick_q <= 5'h00;
      end else if (go && !busy_q) begin
         busy_q <= 1'b1;
         left_q <= pulses;
         tick_q <= 5'h00;
      end else if (busy_q) begin
         tick_q <= tick_q + 5'h01;
         if (tick_q == 5'h0F) begin
            pin_q <= 1'b0;
         end
         if (tick_q == 5'h1F) begin
            pin_q <= 1'b1;
            left_q <= left_q - 8'h01;
            busy_q <= (left_q != 8'h01);
         end
      end
   end
endmodule
`default_nettype wire

// ==== tb.sv ====
/*
 Self-checking bench of the dual timer/counter block.
 Assumes dtc_top and dtc_pin_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dtc_params.svh"
module tb;
   logic        clk_sys;
   logic        sys_rst;
   logic [11:0] aw_addr;
   logic        aw_valid;
   logic        aw_ready;
   logic [31:0] w_data;
   logic        w_valid;
   logic        w_ready;
   logic [1:0]  b_resp;
   logic        b_valid;
   logic        b_ready;
   logic [11:0] ar_addr;
   logic        ar_valid;
   logic        ar_ready;
   logic [31:0] r_data;
   logic [1:0]  r_resp;
   logic        r_valid;
   logic        r_ready;
   logic [1:0]  ext_pin;
   logic        cnt_pin;
   logic        go;
   logic        busy;
   logic        irq;
   logic [7:0]  d;
   int          miscompares;
   int          total_checks;

   dtc_top uut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .AWADDR(aw_addr), .AWVALID(aw_valid),
      .AWREADY(aw_ready), .WDATA(w_data), .WSTRB(4'hF), .WVALID(w_valid), .WREADY(w_ready),
      .BRESP(b_resp), .BVALID(b_valid), .BREADY(b_ready), .ARADDR(ar_addr),
      .ARVALID(ar_valid), .ARREADY(ar_ready), .RDATA(r_data), .RRESP(r_resp),
      .RVALID(r_valid), .RREADY(r_ready), .COUNT_PIN_ZERO(cnt_pin), .COUNT_PIN_ONE(cnt_pin),
      .EXT_IRQ_ZERO_PIN(ext_pin[0]), .EXT_IRQ_ONE_PIN(ext_pin[1]), .IRQ(irq));

   dtc_pin_model pins (.clk(clk_sys), .rst(sys_rst), .go(go), .pulses(8'h03),
      .pin_q(cnt_pin), .busy_q(busy));

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic tmo();
      miscompares++;
      $display("mismatch at %0t: wait ran out %h %h", $time, 8'h00, 8'h01);
      print_verdict();
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Master holds each channel until its own ready, B and R until valid
   task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [1:0] er = 2'h0);
      int n;
      logic aw_done;
      logic w_done;
      n = 0;
      aw_done = 1'b0;
      w_done = 1'b0;
      aw_addr <= a;
      w_data <= {24'h000000, v};
      aw_valid <= 1'b1;
      w_valid <= 1'b1;
      b_ready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge clk_sys);
         n++;
         if (n > 50) tmo();
         if (!aw_done && aw_ready === 1'b1) begin
            aw_done = 1'b1;
            aw_valid <= 1'b0;
         end
         if (!w_done && w_ready === 1'b1) begin
            w_done = 1'b1;
            w_valid <= 1'b0;
         end
      end
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
         if (n > 50) tmo();
      end while (b_valid !== 1'b1);
      chk({6'h00, b_resp}, {6'h00, er});
   endtask

   task automatic rd(input logic [11:0] a, output logic [7:0] v, input logic [1:0] er = 2'h0);
      int n;
      n = 0;
      ar_addr <= a;
      ar_valid <= 1'b1;
      r_ready <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (n > 50) tmo();
      end while (ar_ready !== 1'b1);
      ar_valid <= 1'b0;
      do begin
         @(posedge clk_sys);
         n++;
         if (n > 100) tmo();
      end while (r_valid !== 1'b1);
      v = r_data[7:0];
      chk({6'h00, r_resp}, {6'h00, er});
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [7:0] m, input logic [7:0] exp);
      logic [7:0] v;
      rd(a, v);
      chk(v & m, exp);
   endtask

   // Polls a register field; runs out after 201 reads
   task automatic wait_val(input logic [11:0] a, input logic [7:0] m, input logic [7:0] v);
      logic [7:0] x;
      int n;
      n = 0;
      rd(a, x);
      while ((x & m) !== v) begin
         n++;
         if (n > 200) tmo();
         rd(a, x);
      end
      chk(x & m, v);
   endtask

   task automatic t_reset();
      rd_chk(`DTC_OFS_CTRL, 8'hFF, 8'h00);
      rd_chk(`DTC_OFS_MODE, 8'hFF, 8'h00);
      rd_chk(`DTC_OFS_T0_HIGH, 8'hFF, 8'h00);
      rd(12'h0FC, d, `DTC_RESP_SLVERR);
      wr(12'h0FC, 8'h5A, `DTC_RESP_SLVERR);
      $display("test reset done");
   endtask

   task automatic t_mode1();
      wr(`DTC_OFS_T0_LOW, 8'hFE);
      wr(`DTC_OFS_T0_HIGH, 8'hFF);
      wr(`DTC_OFS_MODE, 8'h01);
      wr(`DTC_OFS_IRQ_MASK, 8'h01);
      wr(`DTC_OFS_CTRL, 8'h10);
      wait_val(`DTC_OFS_CTRL, 8'h20, 8'h20);
      rd_chk(`DTC_OFS_T0_HIGH, 8'hFF, 8'h00);
      chk({7'h00, irq}, 8'h01);
      wr(`DTC_OFS_CTRL, 8'h20);
      rd(`DTC_OFS_T0_LOW, d);
      repeat (30) @(posedge clk_sys);
      rd_chk(`DTC_OFS_T0_LOW, 8'hFF, d);
      wr(`DTC_OFS_VECT_ACK, 8'h01);
      rd_chk(`DTC_OFS_CTRL, 8'hFF, 8'h00);
      wr(`DTC_OFS_IRQ_STAT, 8'h01);
      repeat (2) @(posedge clk_sys);
      chk({7'h00, irq}, 8'h00);
      $display("test mode1 done");
   endtask

   task automatic t_modes();
      wr(`DTC_OFS_MODE, 8'h02);
      wr(`DTC_OFS_T0_HIGH, 8'hF0);
      wr(`DTC_OFS_T0_LOW, 8'hFE);
      wr(`DTC_OFS_CTRL, 8'h10);
      wait_val(`DTC_OFS_CTRL, 8'h20, 8'h20);
      wr(`DTC_OFS_CTRL, 8'h00);
      rd_chk(`DTC_OFS_T0_HIGH, 8'hFF, 8'hF0);
      rd_chk(`DTC_OFS_T0_LOW, 8'hF0, 8'hF0);
      // Mode 0: the upper three low bits stay out of the count
      wr(`DTC_OFS_MODE, 8'h00);
      wr(`DTC_OFS_T0_HIGH, 8'h00);
      wr(`DTC_OFS_T0_LOW, 8'hFE);
      wr(`DTC_OFS_CTRL, 8'h10);
      wait_val(`DTC_OFS_T0_HIGH, 8'hFF, 8'h01);
      wr(`DTC_OFS_CTRL, 8'h00);
      rd_chk(`DTC_OFS_T0_LOW, 8'hE0, 8'hE0);
      // Gating: a low interrupt pin holds the count
      wr(`DTC_OFS_MODE, 8'h09);
      wr(`DTC_OFS_T0_LOW, 8'h00);
      ext_pin[0] <= 1'b0;
      // Let the synchroniser settle before the run bit goes up
      repeat (8) @(posedge clk_sys);
      wr(`DTC_OFS_CTRL, 8'h10);
      repeat (30) @(posedge clk_sys);
      rd_chk(`DTC_OFS_T0_LOW, 8'hFF, 8'h00);
      ext_pin[0] <= 1'b1;
      wait_val(`DTC_OFS_T0_LOW, 8'h01, 8'h01);
      wr(`DTC_OFS_CTRL, 8'h00);
      $display("test modes done");
   endtask

   task automatic t_ext(input int i);
      logic [7:0] fl;
      fl = 8'h02 << (2 * i);
      wr(`DTC_OFS_CTRL, 8'h01 << (2 * i));
      ext_pin[i] <= 1'b0;
      wait_val(`DTC_OFS_CTRL, fl, fl);
      ext_pin[i] <= 1'b1;
      repeat (10) @(posedge clk_sys);
      rd_chk(`DTC_OFS_CTRL, fl, fl);
      wr(`DTC_OFS_VECT_ACK, 8'h04 << i);
      rd_chk(`DTC_OFS_CTRL, fl, 8'h00);
      wr(`DTC_OFS_CTRL, 8'h00);
      ext_pin[i] <= 1'b0;
      wait_val(`DTC_OFS_CTRL, fl, fl);
      wr(`DTC_OFS_VECT_ACK, 8'h04 << i);
      rd_chk(`DTC_OFS_CTRL, fl, fl);
      ext_pin[i] <= 1'b1;
      wait_val(`DTC_OFS_CTRL, fl, 8'h00);
      $display("test ext %0d done", i);
   endtask

   task automatic pulse3();
      int n;
      n = 0;
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      do begin
         @(posedge clk_sys);
         n++;
         if (n > 200) tmo();
      end while (busy !== 1'b0);
      repeat (20) @(posedge clk_sys);
   endtask

   task automatic t_count();
      wr(`DTC_OFS_MODE, 8'h55);
      wr(`DTC_OFS_T1_LOW, 8'h00);
      wr(`DTC_OFS_T0_LOW, 8'h00);
      wr(`DTC_OFS_CTRL, 8'h50);
      pulse3();
      rd_chk(`DTC_OFS_T1_LOW, 8'hFF, 8'h03);
      rd_chk(`DTC_OFS_T0_LOW, 8'hFF, 8'h03);
      wr(`DTC_OFS_CTRL, 8'h00);
      pulse3();
      rd_chk(`DTC_OFS_T1_LOW, 8'hFF, 8'h03);
      rd_chk(`DTC_OFS_T0_LOW, 8'hFF, 8'h03);
      wr(`DTC_OFS_CTRL, 8'h40);
      wr(`DTC_OFS_MODE, 8'h70);
      pulse3();
      rd_chk(`DTC_OFS_T1_LOW, 8'hFF, 8'h03);
      // Split timer 0: high byte ticks on timer 1 run bit, overflow lands in bit 7
      wr(`DTC_OFS_CTRL, 8'h00);
      wr(`DTC_OFS_MODE, 8'h03);
      wr(`DTC_OFS_T0_HIGH, 8'hFE);
      wr(`DTC_OFS_CTRL, 8'h40);
      wait_val(`DTC_OFS_CTRL, 8'h80, 8'h80);
      rd_chk(`DTC_OFS_T0_LOW, 8'hFF, 8'h03);
      wr(`DTC_OFS_CTRL, 8'h00);
      $display("test count done");
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   initial begin
      miscompares = 0;
      total_checks = 0;
      sys_rst = 1'b1;
      aw_addr = 12'h000;
      aw_valid = 1'b0;
      w_data = 32'h00000000;
      w_valid = 1'b0;
      b_ready = 1'b0;
      ar_addr = 12'h000;
      ar_valid = 1'b0;
      r_ready = 1'b0;
      ext_pin = 2'h3;
      go = 1'b0;
      repeat (3) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_reset();
      t_mode1();
      t_modes();
      t_ext(0);
      t_ext(1);
      t_count();
      print_verdict();
   end
endmodule
`default_nettype wire
